// ===== hdl/dws_map.vh
// Constants and timing counts of the droop wake sequencer
`ifndef DWS_MAP_VH
`define DWS_MAP_VH
`define DWS_CLK_HZ 10000000
`define DWS_WAKE_WIDTH_NS 1000
`define DWS_WAKE_REP_NS 30000
`define DWS_MIN_LOW_NS 500
`define DWS_ENABLE_INTERVAL_NS 57000
`define DWS_DISABLE_INTERVAL_NS 177000
`define DWS_NS_CYC(ns) (((ns) * (`DWS_CLK_HZ / 1000000)) / 1000)
`define DWS_WAKE_WIDTH_CYC `DWS_NS_CYC(`DWS_WAKE_WIDTH_NS)
`define DWS_WAKE_REP_CYC `DWS_NS_CYC(`DWS_WAKE_REP_NS)
`define DWS_MIN_LOW_CYC `DWS_NS_CYC(`DWS_MIN_LOW_NS)
`define DWS_ENABLE_INTERVAL_CYC `DWS_NS_CYC(`DWS_ENABLE_INTERVAL_NS)
`define DWS_DISABLE_INTERVAL_CYC `DWS_NS_CYC(`DWS_DISABLE_INTERVAL_NS)
`define DWS_ENABLE_COUNT 32
`define DWS_DISABLE_COUNT 63
`define DWS_REF_NUM 97
`define DWS_REF_DEN 100
`endif

// ===== hdl/dws_sync.v
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module dws_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end
  assign q = sync_reg;
endmodule
`default_nettype wire

// ===== hdl/dws_ref_hold.v
// Droop reference hold register with 97 percent scaling
`timescale 1ns/1ps
`default_nettype none
`include "dws_map.vh"
module dws_ref_hold #(
  parameter W = 12
) (
  input wire clk,
  input wire rst,
  input wire load,
  input wire [W-1:0] supply,
  output reg [W-1:0] ref_out
);
  localparam [7:0] REF_NUM = `DWS_REF_NUM;
  localparam [W+7:0] REF_DEN = `DWS_REF_DEN;
  wire [W+7:0] prod;
  wire [W+7:0] scaled;
  assign prod = {8'h00, supply} * REF_NUM;
  assign scaled = prod / REF_DEN;
  always @(posedge clk) begin
    if (rst) begin
      ref_out <= {W{1'b0}};
    end else if (load) begin
      ref_out <= scaled[W-1:0];
    end
  end
endmodule
`default_nettype wire

// ===== hdl/dws_top.v
// Droop wake sequencer: detect qualify, droop wake pulses, enable control
// Notes on behaviour
// - Everything stays inactive until supply passes the lockout turn-on level.
// - Once on, run until supply falls below turn-off level.
// - Sample trigger at demag end only after wake low beyond minimum time.
// - Each qualified detect loads reference as 97 percent of supply.
// - Unqualified wake activity leaves the stored reference unchanged.
// - Supply below held reference raises a wake request.
// - Wake line is detect input and pulsed ground switch output.
// - Pulses repeat while requested; stop on detect or lockout.
// - Each detected power cycle refreshes reference and stops pulses.
// - Without controller response pulses repeat and reference holds.
// - Detect during droop reloads reference, delaying the next request.
// - Enable output driven low after sustained slow power cycles.
// - Enable released after 32 cumulative short-period cycles.
// - Low needs 63 consecutive long cycles; one shorter clears count.
// - While low, long cycles never clear the cumulative count.
// - At power-up enable output released and stays while cycles short.
// - Wake events leave enable state and its counters unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "dws_map.vh"
module dws_top #(
  parameter SW = 12,
  parameter PW = 16,
  parameter MIN_LOW_CYC = `DWS_MIN_LOW_CYC,
  parameter WAKE_W_CYC = `DWS_WAKE_WIDTH_CYC,
  parameter WAKE_REP_CYC = `DWS_WAKE_REP_CYC,
  parameter EN_INT_CYC = `DWS_ENABLE_INTERVAL_CYC,
  parameter DIS_INT_CYC = `DWS_DISABLE_INTERVAL_CYC,
  parameter EN_CNT_N = `DWS_ENABLE_COUNT,
  parameter DIS_CNT_N = `DWS_DISABLE_COUNT
) (
  input wire I_REF_CLK,
  input wire I_RST,
  input wire I_UV_ON_ABOVE,
  input wire I_UV_OFF_BELOW,
  input wire I_WAKE_BELOW_THRESH,
  input wire I_DEMAG_END,
  input wire [SW-1:0] I_SUPPLY,
  output wire [SW-1:0] O_DROOP_REF,
  output wire O_SAMPLE_TRIG,
  output wire O_WAKE_OUT,
  output wire O_WAKE_OE_N,
  output wire O_ENABLE_OUT,
  output wire O_ENABLE_OE_N,
  output wire O_ACTIVE
);
  // Cycle counts cut to the counter widths
  localparam [PW-1:0] MIN_LOW = MIN_LOW_CYC[PW-1:0];
  localparam [PW-1:0] WAKE_W = WAKE_W_CYC[PW-1:0];
  localparam [PW-1:0] WAKE_REP = WAKE_REP_CYC[PW-1:0];
  localparam [PW-1:0] EN_INT = EN_INT_CYC[PW-1:0];
  localparam [PW-1:0] DIS_INT = DIS_INT_CYC[PW-1:0];
  localparam [5:0] EN_CNT = EN_CNT_N[5:0];
  localparam [5:0] DIS_CNT = DIS_CNT_N[5:0];
  localparam ST_OFF = 1'b0;
  localparam ST_ON = 1'b1;

  wire [3:0] sync_q;
  wire uv_on;
  wire uv_off;
  wire wake_low;
  wire demag_end;
  wire [SW-1:0] supply_q;
  wire [SW-1:0] droop_ref;

  dws_sync #(.W(4)) u_sync (
    .clk(I_REF_CLK),
    .rst(I_RST),
    .d({I_UV_ON_ABOVE, I_UV_OFF_BELOW, I_WAKE_BELOW_THRESH, I_DEMAG_END}),
    .q(sync_q)
  );
  assign uv_on = sync_q[3];
  assign uv_off = sync_q[2];
  assign wake_low = sync_q[1];
  assign demag_end = sync_q[0];

  // Supply code is taken as slow, so per-bit syncing is safe
  dws_sync #(.W(SW)) u_sup (
    .clk(I_REF_CLK),
    .rst(I_RST),
    .d(I_SUPPLY),
    .q(supply_q)
  );

  reg state_reg;
  reg state_next;
  reg [PW-1:0] low_cnt_reg;
  reg qual_reg;
  reg demag_d_reg;
  reg trig_reg;
  reg ref_valid_reg;
  reg wake_req_reg;
  reg [PW-1:0] osc_cnt_reg;
  reg pulse_reg;
  reg [PW-1:0] period_reg;
  reg seen_reg;
  reg [5:0] dis_cnt_reg;
  reg [5:0] en_cnt_reg;
  reg ens_low_reg;

  // Counter step that sticks at all ones
  function [PW-1:0] step_sat;
    input [PW-1:0] v;
    begin
      if (v == {PW{1'b1}}) begin
        step_sat = v;
      end else begin
        step_sat = v + 1'b1;
      end
    end
  endfunction

  // Counter step that wraps to zero after lim - 1
  function [PW-1:0] step_wrap;
    input [PW-1:0] v;
    input [PW-1:0] lim;
    begin
      if (v >= lim - 1'b1) begin
        step_wrap = {PW{1'b0}};
      end else begin
        step_wrap = v + 1'b1;
      end
    end
  endfunction

  // Next value of a six-bit cycle count
  function [5:0] step6;
    input [5:0] v;
    begin
      step6 = v + 6'h01;
    end
  endfunction

  // One more cycle brings the count to its limit
  function reach6;
    input [5:0] v;
    input [5:0] lim;
    begin
      reach6 = (step6(v) >= lim);
    end
  endfunction

  wire active;
  wire detect;
  wire wake_on;
  wire pulse_win;
  wire period_done;
  wire long_cycle;
  wire short_cycle;
  assign active = (state_reg == ST_ON);
  assign wake_on = ref_valid_reg && (supply_q < droop_ref);
  assign pulse_win = (osc_cnt_reg < WAKE_W);
  // Only a detect with a known start closes a period
  assign period_done = detect && seen_reg;
  assign long_cycle = (period_reg > DIS_INT);
  assign short_cycle = (period_reg < EN_INT);

  always @* begin
    case (state_reg)
      ST_OFF: state_next = uv_on ? ST_ON : ST_OFF;
      ST_ON: state_next = uv_off ? ST_OFF : ST_ON;
      default: state_next = ST_OFF;
    endcase
  end

  always @(posedge I_REF_CLK) begin
    if (I_RST) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always @(posedge I_REF_CLK) begin
    if (I_RST || !active) begin
      low_cnt_reg <= {PW{1'b0}};
      qual_reg <= 1'b0;
      demag_d_reg <= 1'b0;
    end else begin
      demag_d_reg <= demag_end;
      // Own wake pulse lows the line too, so it never qualifies
      if (!wake_low || pulse_reg) begin
        low_cnt_reg <= {PW{1'b0}};
        qual_reg <= 1'b0;
      end else if (low_cnt_reg >= MIN_LOW) begin
        qual_reg <= 1'b1;
      end else begin
        low_cnt_reg <= step_sat(low_cnt_reg);
      end
    end
  end

  assign detect = active && demag_end && !demag_d_reg && qual_reg;

  always @(posedge I_REF_CLK) begin
    if (I_RST) begin
      trig_reg <= 1'b0;
      ref_valid_reg <= 1'b0;
    end else begin
      trig_reg <= detect;
      // No wake until a first detect has stored a reference
      if (!active) begin
        ref_valid_reg <= 1'b0;
      end else if (detect) begin
        ref_valid_reg <= 1'b1;
      end
    end
  end

  dws_ref_hold #(.W(SW)) u_ref (
    .clk(I_REF_CLK),
    .rst(I_RST),
    .load(detect),
    .supply(supply_q),
    .ref_out(droop_ref)
  );

  always @(posedge I_REF_CLK) begin
    if (I_RST || !active) begin
      wake_req_reg <= 1'b0;
    end else if (detect) begin
      wake_req_reg <= 1'b0;
    end else begin
      wake_req_reg <= wake_on;
    end
  end

  always @(posedge I_REF_CLK) begin
    if (I_RST || !active || !wake_req_reg || detect) begin
      osc_cnt_reg <= {PW{1'b0}};
      pulse_reg <= 1'b0;
    end else begin
      osc_cnt_reg <= step_wrap(osc_cnt_reg, WAKE_REP);
      pulse_reg <= pulse_win;
    end
  end

  assign O_WAKE_OUT = 1'b0;
  assign O_WAKE_OE_N = ~pulse_reg;

  always @(posedge I_REF_CLK) begin
    if (I_RST || !active) begin
      period_reg <= {PW{1'b0}};
      seen_reg <= 1'b0;
    end else if (detect) begin
      period_reg <= {PW{1'b0}};
      seen_reg <= 1'b1;
    end else begin
      // Sticks at full scale so a very slow cycle still reads long
      period_reg <= step_sat(period_reg);
    end
  end

  // enable counters, stepped only on a detect that closes a period (period_done), cleared while inactive
  always @(posedge I_REF_CLK) begin
    if (I_RST || !active) begin
      dis_cnt_reg <= 6'h00;
      en_cnt_reg <= 6'h00;
      ens_low_reg <= 1'b0;
    end else if (period_done) begin
      if (!ens_low_reg) begin
        if (long_cycle) begin
          if (reach6(dis_cnt_reg, DIS_CNT)) begin
            ens_low_reg <= 1'b1;
            dis_cnt_reg <= 6'h00;
            en_cnt_reg <= 6'h00;
          end else begin
            dis_cnt_reg <= step6(dis_cnt_reg);
          end
        end else begin
          dis_cnt_reg <= 6'h00;
        end
      end else if (short_cycle) begin
        if (reach6(en_cnt_reg, EN_CNT)) begin
          ens_low_reg <= 1'b0;
          en_cnt_reg <= 6'h00;
          dis_cnt_reg <= 6'h00;
        end else begin
          en_cnt_reg <= step6(en_cnt_reg);
        end
      end
    end
  end

  assign O_ENABLE_OUT = 1'b0;
  assign O_ENABLE_OE_N = ~ens_low_reg;
  assign O_DROOP_REF = droop_ref;
  assign O_SAMPLE_TRIG = trig_reg;
  assign O_ACTIVE = state_reg;
endmodule
`default_nettype wire

// ===== bench/dws_monitor.sv
// Port checker of the droop wake sequencer
`timescale 1ns/1ps
`default_nettype none
module dws_monitor #(parameter SW = 12) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic [SW-1:0] O_DROOP_REF,
  input wire logic O_SAMPLE_TRIG,
  input wire logic O_WAKE_OUT,
  input wire logic O_WAKE_OE_N,
  input wire logic O_ENABLE_OUT,
  input wire logic O_ENABLE_OE_N,
  input wire logic O_ACTIVE
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  a_idle_quiet: assert property (!O_ACTIVE && !$past(O_ACTIVE)
    |-> O_WAKE_OE_N && O_ENABLE_OE_N) else $error("switch on while idle");
  a_trig_single: assert property (O_SAMPLE_TRIG |=> !O_SAMPLE_TRIG)
    else $error("trigger too long");
  a_ref_hold: assert property ($changed(O_DROOP_REF)
    |-> O_SAMPLE_TRIG || !O_ACTIVE || !$past(O_ACTIVE))
    else $error("reference moved");
  a_pulse_len: assert property ($fell(O_WAKE_OE_N) |-> ##10 O_WAKE_OE_N)
    else $error("pulse width");
  a_pulse_gap: assert property ($rose(O_WAKE_OE_N) |=> O_WAKE_OE_N[*8])
    else $error("pulse gap");
  a_pulse_stop: assert property (O_SAMPLE_TRIG |-> O_WAKE_OE_N[*3])
    else $error("pulse after detect");
  a_ens_steady: assert property ($changed(O_ENABLE_OE_N)
    |-> O_SAMPLE_TRIG || $past(O_SAMPLE_TRIG) || $past(O_SAMPLE_TRIG, 2)
    || !O_ACTIVE) else $error("enable moved");
  a_pins_low: assert property (!O_WAKE_OUT && !O_ENABLE_OUT)
    else $error("pin data high");
endmodule
`default_nettype wire

// ===== bench/dws_primary_model.sv
// Primary controller model making power cycles on the wake line
`timescale 1ns/1ps
`default_nettype none
module dws_primary_model (
  input wire logic clk,
  input wire logic wake_oe_n,
  input wire logic respond,
  input wire logic go,
  input wire logic glitch,
  output logic low,
  output logic demag
);
  int n = 0;
  logic oe_q = 1'b1;
  // Rising edge sampling keeps clear of the bench's falling-edge drive
  always @(posedge clk) begin
    oe_q <= wake_oe_n;
    if (n > 0)
      n <= n - 1;
    else if (go || (respond && wake_oe_n && !oe_q))
      n <= 14;
    else if (glitch)
      n <= 6;
  end
  assign low = n >= 3;
  assign demag = n > 0 && n <= 4;
endmodule
`default_nettype wire

// ===== bench/droop_wake_sequencer_tb.sv
// Bench of the droop wake sequencer
`timescale 1ns/1ps
`default_nettype none
module droop_wake_sequencer_tb;
  logic clk = 0, rst = 1, uv_on = 0, uv_off = 0;
  logic go = 0, glitch = 0, respond = 0, oe_q = 1;
  logic [11:0] supply = 12'h3e8;
  wire [11:0] dref;
  wire trig, w_out, w_oe_n, e_out, e_oe_n, active, p_low, p_dm;
  wire below = !w_oe_n || p_low;
  int n_mismatch = 0, n_tests = 0, n_trig = 0, n_wake = 0, cyc = 0, t0 = 0;
  int gap = 0;
  initial forever #50 clk = !clk;
  // Short cycle intervals keep the 63-cycle disable run brief
  dws_top #(.EN_INT_CYC(200), .DIS_INT_CYC(600)) dws_top_i (
    .I_REF_CLK(clk), .I_RST(rst), .I_UV_ON_ABOVE(uv_on),
    .I_UV_OFF_BELOW(uv_off), .I_WAKE_BELOW_THRESH(below),
    .I_DEMAG_END(p_dm), .I_SUPPLY(supply), .O_DROOP_REF(dref),
    .O_SAMPLE_TRIG(trig), .O_WAKE_OUT(w_out), .O_WAKE_OE_N(w_oe_n),
    .O_ENABLE_OUT(e_out), .O_ENABLE_OE_N(e_oe_n), .O_ACTIVE(active));
  dws_primary_model dws_primary_model_i (.clk(clk), .wake_oe_n(w_oe_n),
    .respond(respond), .go(go), .glitch(glitch), .low(p_low), .demag(p_dm));
  always @(posedge clk) begin
    cyc++;
    oe_q <= w_oe_n;
    if (trig === 1'b1) n_trig++;
    if (oe_q && w_oe_n === 1'b0) begin
      n_wake++;
      gap = cyc - t0;
      t0 = cyc;
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task pc(input int len);
    @(negedge clk) go = 1;
    @(negedge clk) go = 0;
    repeat (len - 2) @(negedge clk);
  endtask
  task t_lockout;
    pc(100);
    chk(16'(n_trig), 16'h0);
    uv_on = 1;
    repeat (6) @(negedge clk);
    chk(16'(active), 16'h1);
  endtask
  task t_glitch;
    pc(500);
    chk(16'(dref), 16'h3ca);
    supply = 12'h3fc;
    @(negedge clk) glitch = 1;
    @(negedge clk) glitch = 0;
    repeat (40) @(negedge clk);
    chk(16'(n_trig), 16'h1);
    chk(16'(dref), 16'h3ca);
  endtask
  task t_droop;
    supply = 12'h384;
    repeat (650) @(negedge clk);
    chk(16'(n_wake), 16'h3);
    chk(16'(gap), 16'h12c);
    chk(16'(dref), 16'h3ca);
    respond = 1;
    repeat (400) @(negedge clk);
    respond = 0;
    chk(16'(dref), 16'h369);
    repeat (400) @(negedge clk);
    chk(16'(n_wake), 16'h4);
  endtask
  task t_midroop;
    supply = 12'h370;
    pc(500);
    chk(16'(dref), 16'h355);
    chk(16'(n_wake), 16'h4);
  endtask
  task t_enable;
    repeat (63) pc(700);
    chk(16'(e_oe_n), 16'h1);
    pc(700);
    chk(16'(e_oe_n), 16'h0);
    repeat (31) pc(150);
    pc(400);
    pc(150);
    chk(16'(e_oe_n), 16'h0);
    pc(150);
    chk(16'(e_oe_n), 16'h1);
  endtask
  task t_undervoltage_lockout;
    uv_off = 1;
    uv_on = 0;
    repeat (8) @(negedge clk);
    chk(16'(active), 16'h0);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    t_lockout;
    t_glitch;
    t_droop;
    t_midroop;
    t_enable;
    t_undervoltage_lockout;
    report_and_stop;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end
endmodule
bind dws_top dws_monitor #(.SW(SW)) dws_monitor_i (.I_REF_CLK(I_REF_CLK),
  .I_RST(I_RST), .O_DROOP_REF(O_DROOP_REF), .O_SAMPLE_TRIG(O_SAMPLE_TRIG),
  .O_WAKE_OUT(O_WAKE_OUT), .O_WAKE_OE_N(O_WAKE_OE_N),
  .O_ENABLE_OUT(O_ENABLE_OUT), .O_ENABLE_OE_N(O_ENABLE_OE_N),
  .O_ACTIVE(O_ACTIVE));
`default_nettype wire
